// ==== hdl/urc_top.sv ====
module urc_top #(
  parameter int ADDR_W = 8,
  parameter int DEPTH = urc_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic receive_data_pin,
  input wire logic transmit_clock_pin_in,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe_n,
  output logic serial_pins_owned
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic serial_port_on_reg, serial_port_on_next;
  logic ninth_bit_receive_select_reg, ninth_bit_receive_select_next;
  logic single_receive_request_reg, single_receive_request_next;
  logic continuous_receive_on_reg, continuous_receive_on_next;
  logic address_detect_on_reg, address_detect_on_next;
  logic framing_fault_flag_reg, framing_fault_flag_next;
  logic overrun_fault_flag_reg, overrun_fault_flag_next;
  logic received_ninth_bit_reg, received_ninth_bit_next;
  logic sync_reg, sync_next, master_reg, master_next;
  logic [15:0] baud_reg, baud_next;

  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  logic wr_fire, rd_fire, aw_take, w_take;
  logic [7:0] rd_addr;
  logic [7:0] rcs_view;
  logic run, eng_busy, eng_done, eng_stop_ok, eng_clk_out;
  logic [8:0] eng_word;
  logic accept, addr_filter;

  urc_stream_if #(.W(urc_pkg::WORD_W)) fill_s ();
  urc_stream_if #(.W(urc_pkg::WORD_W)) drain_s ();

  // ---------------------------------------------------------------
  // receive engine and buffer
  // ---------------------------------------------------------------
  // single receive only counts as synchronous master; async ignores it
  always_comb begin
    if (!serial_port_on_reg || overrun_fault_flag_reg) begin
      run = 1'b0;
    end else if (sync_reg && master_reg) begin
      run = single_receive_request_reg || continuous_receive_on_reg;
    end else begin
      run = continuous_receive_on_reg;
    end
  end

  urc_rx_shift #(.DW(urc_pkg::DIV_W)) u_shift (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(run),
    .nine(ninth_bit_receive_select_reg),
    .sync_mode(sync_reg),
    .master(master_reg),
    .divisor(baud_reg),
    .data_in(receive_data_pin),
    .clk_in(transmit_clock_pin_in),
    .clk_out(eng_clk_out),
    .busy(eng_busy),
    .done(eng_done),
    .word(eng_word),
    .stop_ok(eng_stop_ok)
  );

  // address filter only in async nine-bit mode
  assign addr_filter = address_detect_on_reg && ninth_bit_receive_select_reg
    && !sync_reg;
  assign accept = eng_done && (!addr_filter || eng_word[8]);

  assign fill_s.data = eng_word;
  assign fill_s.valid = accept;

  urc_fifo #(.W(urc_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // pins belong to the port only while enabled; clock driven only as sync master
  assign serial_pins_owned = serial_port_on_reg;
  assign transmit_clock_pin_out = eng_clk_out;
  assign transmit_clock_pin_oe_n = !(serial_port_on_reg && sync_reg && master_reg
    && eng_busy);

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  assign aw_take = s_axi_awvalid && !aw_have_reg;
  assign w_take = s_axi_wvalid && !w_have_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign rd_addr = {s_axi_araddr[7:2], 2'h0};
  // a data read pops one word; reading an empty buffer pops nothing
  assign drain_s.ready = rd_fire && (rd_addr == urc_pkg::OFF_DATA);

  always_comb begin
    rcs_view = '0;
    rcs_view[urc_pkg::BIT_SERIAL_PORT_ON] = serial_port_on_reg;
    rcs_view[urc_pkg::BIT_RX9] = ninth_bit_receive_select_reg;
    rcs_view[urc_pkg::BIT_SINGLE_RECEIVE_REQUEST] = single_receive_request_reg;
    rcs_view[urc_pkg::BIT_CONTINUOUS_RECEIVE_ON] = continuous_receive_on_reg;
    rcs_view[urc_pkg::BIT_ADDRESS_DETECT_ON] = address_detect_on_reg;
    rcs_view[urc_pkg::BIT_FRAMING_FAULT_FLAG] = framing_fault_flag_reg;
    rcs_view[urc_pkg::BIT_OVERRUN_FAULT_FLAG] = overrun_fault_flag_reg;
    rcs_view[urc_pkg::BIT_RECEIVED_NINTH_BIT] = received_ninth_bit_reg;
  end

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (aw_take) begin
      aw_have_next = 1'b1;
      awaddr_next = {s_axi_awaddr[7:2], 2'h0};
    end
    if (w_take) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == urc_pkg::OFF_RCS || awaddr_reg == urc_pkg::OFF_MODE
        || awaddr_reg == urc_pkg::OFF_BAUD) ? urc_pkg::RESP_OKAY : urc_pkg::RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = urc_pkg::RESP_OKAY;
      rdata_next = '0;
      case (rd_addr)
        urc_pkg::OFF_RCS: rdata_next[7:0] = rcs_view;
        urc_pkg::OFF_MODE: begin
          rdata_next[urc_pkg::BIT_SYNC] = sync_reg;
          rdata_next[urc_pkg::BIT_MASTER] = master_reg;
        end
        urc_pkg::OFF_BAUD: rdata_next[15:0] = baud_reg;
        urc_pkg::OFF_DATA: begin
          rdata_next[urc_pkg::BIT_DATA_VALID] = drain_s.valid;
          rdata_next[8:0] = drain_s.valid ? drain_s.data : 9'h000;
        end
        default: rresp_next = urc_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control and status
  // ---------------------------------------------------------------
  always_comb begin
    serial_port_on_next = serial_port_on_reg;
    ninth_bit_receive_select_next = ninth_bit_receive_select_reg;
    single_receive_request_next = single_receive_request_reg;
    continuous_receive_on_next = continuous_receive_on_reg;
    address_detect_on_next = address_detect_on_reg;
    framing_fault_flag_next = framing_fault_flag_reg;
    overrun_fault_flag_next = overrun_fault_flag_reg;
    received_ninth_bit_next = received_ninth_bit_reg;
    sync_next = sync_reg;
    master_next = master_reg;
    baud_next = baud_reg;
    // hardware clear first so that a software set in the same cycle wins
    if (eng_done && sync_reg && master_reg) begin
      single_receive_request_next = 1'b0;
    end
    if (wr_fire && awaddr_reg == urc_pkg::OFF_RCS && wstrb_reg[0]) begin
      serial_port_on_next = wdata_reg[urc_pkg::BIT_SERIAL_PORT_ON];
      ninth_bit_receive_select_next = wdata_reg[urc_pkg::BIT_RX9];
      single_receive_request_next = wdata_reg[urc_pkg::BIT_SINGLE_RECEIVE_REQUEST];
      continuous_receive_on_next = wdata_reg[urc_pkg::BIT_CONTINUOUS_RECEIVE_ON];
      address_detect_on_next = wdata_reg[urc_pkg::BIT_ADDRESS_DETECT_ON];
      // dropping continuous receive is how software recovers from overrun
      if (!wdata_reg[urc_pkg::BIT_CONTINUOUS_RECEIVE_ON]) begin
        overrun_fault_flag_next = 1'b0;
      end
    end
    if (wr_fire && awaddr_reg == urc_pkg::OFF_MODE && wstrb_reg[0]) begin
      sync_next = wdata_reg[urc_pkg::BIT_SYNC];
      master_next = wdata_reg[urc_pkg::BIT_MASTER];
    end
    if (wr_fire && awaddr_reg == urc_pkg::OFF_BAUD) begin
      if (wstrb_reg[0]) begin
        baud_next[7:0] = wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        baud_next[15:8] = wdata_reg[15:8];
      end
    end
    if (accept && fill_s.ready) begin
      framing_fault_flag_next = !eng_stop_ok;
      received_ninth_bit_next = eng_word[8];
    end else if (accept) begin
      overrun_fault_flag_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_port_on_reg <= 1'b0;
      ninth_bit_receive_select_reg <= 1'b0;
      single_receive_request_reg <= 1'b0;
      continuous_receive_on_reg <= 1'b0;
      address_detect_on_reg <= 1'b0;
      framing_fault_flag_reg <= 1'b0;
      overrun_fault_flag_reg <= 1'b0;
      received_ninth_bit_reg <= 1'b0;
      sync_reg <= 1'b0;
      master_reg <= 1'b0;
      baud_reg <= urc_pkg::BAUD_RESET;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= urc_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= urc_pkg::RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      serial_port_on_reg <= serial_port_on_next;
      ninth_bit_receive_select_reg <= ninth_bit_receive_select_next;
      single_receive_request_reg <= single_receive_request_next;
      continuous_receive_on_reg <= continuous_receive_on_next;
      address_detect_on_reg <= address_detect_on_next;
      framing_fault_flag_reg <= framing_fault_flag_next;
      overrun_fault_flag_reg <= overrun_fault_flag_next;
      received_ninth_bit_reg <= received_ninth_bit_next;
      sync_reg <= sync_next;
      master_reg <= master_next;
      baud_reg <= baud_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule : urc_top

// ==== inc/urc_pkg.sv ====
// Operation
// - port enable bit 7 hands clock and data pins to the serial port
// - ninth-bit select chooses nine-bit characters, otherwise eight-bit characters
// - single receive bit 5 starts one reception only as synchronous master
// - hardware clears the single receive bit when that reception completes
// - continuous receive bit 4 enables reception while set and no overrun is flagged, in every mode
// - with address detect, only characters with shift bit eight set are loaded
// - address detect acts only in asynchronous mode with nine-bit reception
// - framing fault flag is read-only, resets to zero, zero when none pending
// - overrun fault flag is read-only and reads one after a receive overrun
// - received ninth bit holds the ninth bit of the latest character
// - without address detect every character is accepted, ninth bit usable as parity
package urc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_RCS = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;

  localparam int BIT_SERIAL_PORT_ON = 7;
  localparam int BIT_RX9 = 6;
  localparam int BIT_SINGLE_RECEIVE_REQUEST = 5;
  localparam int BIT_CONTINUOUS_RECEIVE_ON = 4;
  localparam int BIT_ADDRESS_DETECT_ON = 3;
  localparam int BIT_FRAMING_FAULT_FLAG = 2;
  localparam int BIT_OVERRUN_FAULT_FLAG = 1;
  localparam int BIT_RECEIVED_NINTH_BIT = 0;
  localparam int BIT_SYNC = 0;
  localparam int BIT_MASTER = 1;
  localparam int BIT_DATA_VALID = 15;

  localparam logic [15:0] BAUD_RESET = 16'h043D;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // datapath shape
  // ---------------------------------------------------------------
  localparam int WORD_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int DIV_W = 16;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} urc_rx_state_t;

endpackage : urc_pkg

// ==== inc/urc_stream_if.sv ====
interface urc_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : urc_stream_if

// ==== hdl/urc_fifo.sv ====
module urc_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  urc_stream_if.snk in_s,
  urc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic push, pop, full, empty;

  // depth must be a power of two: the extra pointer bit tells full from empty
  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_reg[AW-1:0]];
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_s.data;
    end
  end

endmodule : urc_fifo

// ==== hdl/urc_rx_shift.sv ====
module urc_rx_shift #(
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic nine,
  input wire logic sync_mode,
  input wire logic master,
  input wire logic [DW-1:0] divisor,
  input wire logic data_in,
  input wire logic clk_in,
  output logic clk_out,
  output logic busy,
  output logic done,
  output logic [8:0] word,
  output logic stop_ok
);
  urc_pkg::urc_rx_state_t st_reg, st_next;
  logic [DW-1:0] cnt_reg, cnt_next;
  logic [8:0] sh_reg, sh_next, word_reg, word_next;
  logic [3:0] nb_reg, nb_next, nbits;
  logic ck_reg, ck_next, ckin_reg, done_reg, done_next, stop_reg, stop_next;
  logic tick, sample, last;

  assign nbits = nine ? urc_pkg::BITS_NINE : urc_pkg::BITS_EIGHT;
  assign tick = (cnt_reg == '0);
  // slave samples on the peer clock rising edge, master on its own
  assign sample = sync_mode ? (master ? (tick && !ck_reg) : (clk_in && !ckin_reg)) : tick;
  assign last = (nb_reg == nbits - 4'h1);
  assign clk_out = ck_reg;
  assign busy = (st_reg != urc_pkg::RX_IDLE);
  assign done = done_reg;
  assign word = word_reg;
  assign stop_ok = stop_reg;

  always_comb begin
    st_next = st_reg;
    cnt_next = tick ? divisor : cnt_reg - 1'b1;
    sh_next = sh_reg;
    nb_next = nb_reg;
    ck_next = ck_reg;
    word_next = word_reg;
    stop_next = stop_reg;
    done_next = 1'b0;
    case (st_reg)
      urc_pkg::RX_IDLE: begin
        ck_next = 1'b0;
        nb_next = '0;
        if (run && !sync_mode && !data_in) begin
          st_next = urc_pkg::RX_START;
          cnt_next = divisor >> 1;
        end else if (run && sync_mode) begin
          st_next = urc_pkg::RX_BITS;
          cnt_next = divisor;
        end
      end
      urc_pkg::RX_START: begin
        // a start bit shorter than half a bit is noise
        if (tick) begin
          st_next = data_in ? urc_pkg::RX_IDLE : urc_pkg::RX_BITS;
        end
      end
      urc_pkg::RX_BITS: begin
        if (sync_mode && master && tick) begin
          ck_next = !ck_reg;
        end
        if (sample) begin
          sh_next = {data_in, sh_reg[8:1]};
          nb_next = nb_reg + 4'h1;
          if (last && !sync_mode) begin
            st_next = urc_pkg::RX_STOP;
          end else if (last) begin
            st_next = urc_pkg::RX_IDLE;
            done_next = 1'b1;
            stop_next = 1'b1;
            word_next = nine ? sh_next : {1'b0, sh_next[8:1]};
          end
        end
      end
      urc_pkg::RX_STOP: begin
        if (tick) begin
          st_next = urc_pkg::RX_IDLE;
          done_next = 1'b1;
          stop_next = data_in;
          word_next = nine ? sh_reg : {1'b0, sh_reg[8:1]};
        end
      end
      default: st_next = urc_pkg::RX_IDLE;
    endcase
    if (!run) begin
      st_next = urc_pkg::RX_IDLE;
      done_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= urc_pkg::RX_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      nb_reg <= '0;
      ck_reg <= 1'b0;
      ckin_reg <= 1'b0;
      word_reg <= '0;
      stop_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      nb_reg <= nb_next;
      ck_reg <= ck_next;
      ckin_reg <= clk_in;
      word_reg <= word_next;
      stop_reg <= stop_next;
      done_reg <= done_next;
    end
  end

endmodule : urc_rx_shift

// ==== verif/urc_properties.sv ====
module urc_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic transmit_clock_pin_oe_n,
  input wire logic serial_pins_owned
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr_both;
  logic serial_port_on_seen_reg;
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // keeps the enable bit of the last accepted write for the two-cycle check
  always_ff @(posedge sys_clk) begin
    if (wr_both) begin
      serial_port_on_seen_reg <= s_axi_wdata[7];
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=>
    !s_axi_bvalid && !s_axi_rvalid && transmit_clock_pin_oe_n && !serial_pins_owned)
    else $error("outputs not idle after reset");
  AST_PORT_ENABLE: assert property (
    wr_both && s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0]
    |-> ##2 serial_pins_owned == serial_port_on_seen_reg) else $error("port enable not applied");
  AST_DRIVE_OWNED: assert property (!transmit_clock_pin_oe_n |-> serial_pins_owned)
    else $error("clock pin driven while port off");
  AST_WRITE_ANSWER: assert property (wr_both |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write response not two edges after handshake");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  AST_AW_BLOCKED: assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("held write not answered");
  COV_WRITE: cover property (wr_both);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_DRIVE: cover property (!transmit_clock_pin_oe_n);
endmodule : urc_properties

bind urc_top urc_properties #(.ADDR_W(ADDR_W)) u_props (.sys_clk(sys_clk), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .transmit_clock_pin_oe_n(transmit_clock_pin_oe_n), .serial_pins_owned(serial_pins_owned));

// ==== verif/urc_serial_peer.sv ====
module urc_serial_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle is mark level; the peer drives the line high, so a quiet peer reads high
  initial line = 1'b1;
  task automatic send(input logic [8:0] w, input int nbits, input logic stop);
    for (int i = 0; i < nbits + 2; i++) begin
      @(posedge sys_clk);
      line <= (i == 0) ? 1'b0 : (i <= nbits) ? w[i-1] : stop;
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
    // one idle bit time so the next start edge is clean
    @(posedge sys_clk);
    line <= 1'b1;
    repeat (BIT_CYC - 1) @(posedge sys_clk);
  endtask : send
endmodule : urc_serial_peer

// ==== verif/test_usart_receive_control_status.sv ====
module test_usart_receive_control_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_line, ck_out, oe_n, owned, ck_wire;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0;
  int comparisons = 0;
  // the clock pin is pulled low when nobody drives it
  assign ck_wire = oe_n ? 1'b0 : ck_out;
  always #4 sys_clk = ~sys_clk;
  urc_top dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .receive_data_pin(rx_line), .transmit_clock_pin_in(ck_wire),
    .transmit_clock_pin_out(ck_out), .transmit_clock_pin_oe_n(oe_n), .serial_pins_owned(owned));
  urc_serial_peer #(.BIT_CYC(BIT_CYC)) peer (.sys_clk(sys_clk), .line(rx_line));
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    if (n >= 200) miscompares++;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 200) miscompares++;
  endtask : rd
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, e, d);
    chk("rresp", {30'h0, urc_pkg::RESP_OKAY}, {30'h0, r});
  endtask : rdc
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    rdc("rcs", urc_pkg::OFF_RCS, 32'h0);
    rdc("baud", urc_pkg::OFF_BAUD, {16'h0, urc_pkg::BAUD_RESET});
    rdc("data", urc_pkg::OFF_DATA, 32'h0);
    rd(8'h10, d, r);
    chk("bad rresp", {30'h0, urc_pkg::RESP_SLVERR}, {30'h0, r});
    chk("bad rdata", 32'h0, d);
    wr(8'h10, 32'hFF, urc_pkg::RESP_SLVERR);
  endtask : t_reset_unmapped
  task automatic t_async8;
    wr(urc_pkg::OFF_BAUD, BIT_CYC - 1, urc_pkg::RESP_OKAY);
    wr(urc_pkg::OFF_RCS, 32'h90, urc_pkg::RESP_OKAY);
    chk("owned", 32'h1, {31'h0, owned});
    peer.send(9'h0A5, 8, 1'b1);
    rdc("data8", urc_pkg::OFF_DATA, 32'h80A5);
    peer.send(9'h03C, 8, 1'b0);
    rdc("framing_fault_flag set", urc_pkg::OFF_RCS, 32'h94);
    rdc("data bad stop", urc_pkg::OFF_DATA, 32'h803C);
    wr(urc_pkg::OFF_RCS, 32'h96, urc_pkg::RESP_OKAY);
    peer.send(9'h0C3, 8, 1'b1);
    rdc("framing_fault_flag clear", urc_pkg::OFF_RCS, 32'h90);
    rdc("data8b", urc_pkg::OFF_DATA, 32'h80C3);
  endtask : t_async8
  task automatic t_address;
    wr(urc_pkg::OFF_RCS, 32'hD8, urc_pkg::RESP_OKAY);
    peer.send(9'h055, 9, 1'b1);
    peer.send(9'h1AA, 9, 1'b1);
    rdc("addr kept", urc_pkg::OFF_DATA, 32'h81AA);
    rdc("addr dropped", urc_pkg::OFF_DATA, 32'h0);
    rdc("ninth set", urc_pkg::OFF_RCS, 32'hD9);
    wr(urc_pkg::OFF_RCS, 32'hD0, urc_pkg::RESP_OKAY);
    peer.send(9'h033, 9, 1'b1);
    rdc("no detect", urc_pkg::OFF_DATA, 32'h8033);
    rdc("ninth clear", urc_pkg::OFF_RCS, 32'hD0);
    wr(urc_pkg::OFF_RCS, 32'h98, urc_pkg::RESP_OKAY);
    peer.send(9'h011, 8, 1'b1);
    rdc("detect 8 bit", urc_pkg::OFF_DATA, 32'h8011);
  endtask : t_address
  task automatic t_overrun;
    wr(urc_pkg::OFF_RCS, 32'h90, urc_pkg::RESP_OKAY);
    for (int i = 0; i < 9; i++) peer.send(9'h040 + 9'(i), 8, 1'b1);
    rdc("overrun_fault_flag set", urc_pkg::OFF_RCS, 32'h92);
    for (int i = 0; i < 8; i++) rdc("drain", urc_pkg::OFF_DATA, 32'h8040 + i);
    rdc("drained", urc_pkg::OFF_DATA, 32'h0);
    wr(urc_pkg::OFF_RCS, 32'h80, urc_pkg::RESP_OKAY);
    rdc("overrun_fault_flag clear", urc_pkg::OFF_RCS, 32'h80);
    peer.send(9'h055, 8, 1'b1);
    rdc("continuous_receive_on off", urc_pkg::OFF_DATA, 32'h0);
  endtask : t_overrun
  task automatic t_single;
    logic [31:0] d;
    logic [1:0] r;
    wr(urc_pkg::OFF_RCS, 32'hA0, urc_pkg::RESP_OKAY);
    repeat (400) @(posedge sys_clk);
    rdc("single async", urc_pkg::OFF_DATA, 32'h0);
    wr(urc_pkg::OFF_MODE, 32'h3, urc_pkg::RESP_OKAY);
    wr(urc_pkg::OFF_BAUD, 32'h4, urc_pkg::RESP_OKAY);
    wr(urc_pkg::OFF_RCS, 32'hA0, urc_pkg::RESP_OKAY);
    chk("clk drive", 32'h0, {31'h0, oe_n});
    for (int i = 0; i < 100; i++) begin
      rd(urc_pkg::OFF_RCS, d, r);
      if (d[5] === 1'b0) break;
    end
    rdc("single done", urc_pkg::OFF_RCS, 32'h80);
    chk("clk idle", 32'h2, {30'h0, oe_n, ck_out});
    rdc("single data", urc_pkg::OFF_DATA, 32'h80FF);
  endtask : t_single
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_unmapped();
    t_async8();
    t_address();
    t_overrun();
    t_single();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
endmodule : test_usart_receive_control_status
